// file: core/flash_host_ctrl.sv
// host controller driving a parallel nor flash through its pins, ordered over apb
// Operation
// - status may be polled by ordinary reads while program or erase runs
// - host waits the full chip-select access time before taking read data
// - host should restart any program or erase interrupted by reset
// - host waits the release-to-read time after reset before reading
// - programmer identification uses elevated voltage on A9 plus A6, A1, A0
// - host puts the sector address on high address bits for protect check
// - identification is also entered by command writes, no elevated voltage
// - two unlock writes then the id command; reads may then repeat freely
// - host writes the reset command to leave identification mode
`include "flash_host_regs.svh"
module flash_host_ctrl (
    input  wire logic                        i_mclk,
    input  wire logic                        i_reset_n,
    input  wire logic                        i_psel,
    input  wire logic                        i_penable,
    input  wire logic                        i_pwrite,
    input  wire logic [7:0]                  i_paddr,
    input  wire logic [31:0]                 i_pwdata,
    output logic      [31:0]                 o_prdata,
    output logic                             o_pready,
    output logic                             o_pslverr,
    output flash_host_pkg::flash_pins_t      o_pins,
    input  wire logic [15:0]                 i_dq,
    output logic      [15:0]                 o_dq,
    output logic      [15:0]                 o_dq_oe,
    input  wire logic                        i_op_done_flag
);
    // ==================================================
    // reset release through two flip-flops
    logic rst_meta_ff;
    logic rst_n_ff;
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // ==================================================
    // state
    flash_host_pkg::state_t      state_ff,   nxt_state;
    flash_host_pkg::op_t         op_ff,      nxt_op;
    flash_host_pkg::flash_pins_t pins_ff,    nxt_pins;
    logic [15:0] cnt_ff,     nxt_cnt;
    logic [1:0]  seq_ff,     nxt_seq;
    logic [19:0] addr_ff,    nxt_addr;
    logic [15:0] wdata_ff,   nxt_wdata;
    logic [15:0] rdata_ff,   nxt_rdata;
    logic [15:0] dq_ff,      nxt_dq;
    logic [15:0] dq_oe_ff,   nxt_dq_oe;
    logic        byte_ff,    nxt_byte;
    logic        top_ff,     nxt_top;
    logic        hv_cfg_ff,  nxt_hv_cfg;
    logic        id_mode_ff, nxt_id_mode;
    logic        redo_ff,    nxt_redo;
    logic        refused_ff, nxt_refused;
    logic [31:0] prdata_ff,  nxt_prdata;
    logic        pready_ff,  nxt_pready;
    logic        pslverr_ff, nxt_pslverr;
    logic        acc_wr;
    logic        seq_last;
    logic [19:0] cmd_addr;
    logic [15:0] cmd_data;
    logic [6:0]  sec_bits;
    logic [4:0]  sector_index;

    // device address bits A18..A12 for either width
    assign sec_bits = byte_ff ? addr_ff[19:13] : addr_ff[18:12];

    always_comb begin
        if (top_ff) begin
            if (sec_bits[6:3] != 4'hF)       sector_index = {1'b0, sec_bits[6:3]};
            else if (!sec_bits[2])           sector_index = 5'h0F;
            else if (sec_bits[1])            sector_index = 5'h12;
            else                             sector_index = sec_bits[0] ? 5'h11 : 5'h10;
        end else begin
            if (sec_bits[6:3] != 4'h0)       sector_index = 5'({1'b0, sec_bits[6:3]} + 5'h03);
            else if (sec_bits[2])            sector_index = 5'h03;
            else if (sec_bits[1])            sector_index = sec_bits[0] ? 5'h02 : 5'h01;
            else                             sector_index = 5'h00;
        end
    end

    // last step of the running command
    assign seq_last = (op_ff != flash_host_pkg::OP_ID_ENTER) || (seq_ff == 2'd2);
    // command word of the next write step, so address and data register on the same edge as the strobe falls
    always_comb begin
        cmd_addr = nxt_addr;
        cmd_data = nxt_wdata;
        // two unlock writes then the identification command
        if (nxt_op == flash_host_pkg::OP_ID_ENTER) begin
            unique case (nxt_seq)
                2'd0: begin
                    cmd_addr = nxt_byte ? `UNLOCK1_BADDR : `UNLOCK1_WADDR;
                    cmd_data = `UNLOCK1_DATA;
                end
                2'd1: begin
                    cmd_addr = nxt_byte ? `UNLOCK2_BADDR : `UNLOCK2_WADDR;
                    cmd_data = `UNLOCK2_DATA;
                end
                default: begin
                    cmd_addr = nxt_byte ? `UNLOCK1_BADDR : `UNLOCK1_WADDR;
                    cmd_data = `ID_CMD_DATA;
                end
            endcase
        end else if (nxt_op == flash_host_pkg::OP_ID_EXIT) begin
            cmd_data = `RESET_CMD_DATA;
        end
    end

    // next values: apb slave and sequencer
    always_comb begin
        nxt_state   = state_ff;
        nxt_op      = op_ff;
        nxt_cnt     = cnt_ff;
        nxt_seq     = seq_ff;
        nxt_addr    = addr_ff;
        nxt_wdata   = wdata_ff;
        nxt_rdata   = rdata_ff;
        nxt_byte    = byte_ff;
        nxt_top     = top_ff;
        nxt_hv_cfg  = hv_cfg_ff;
        nxt_id_mode = id_mode_ff;
        nxt_redo    = redo_ff;
        nxt_refused = refused_ff;
        nxt_prdata  = prdata_ff;
        nxt_pslverr = 1'b0;
        nxt_pready  = i_psel && i_penable && !pready_ff;
        acc_wr      = i_psel && i_penable && pready_ff && i_pwrite;
        // read data and error registered on the same edge as pready
        if (nxt_pready) begin
            nxt_prdata = 32'h0000_0000;
            unique case (i_paddr)
                `REG_CTRL:   nxt_prdata = {25'h0, hv_cfg_ff, top_ff, byte_ff, op_ff, 1'b0};
                `REG_ADDR:   nxt_prdata = {12'h000, addr_ff};
                `REG_WDATA:  nxt_prdata = {16'h0000, wdata_ff};
                `REG_RDATA:  nxt_prdata = {16'h0000, rdata_ff};
                `REG_STATUS: nxt_prdata = {19'h0, sector_index, 3'h0, refused_ff, redo_ff,
                                           i_op_done_flag, id_mode_ff, state_ff != flash_host_pkg::S_IDLE};
                default:     nxt_pslverr = 1'b1;
            endcase
        end
        // register writes; sticky flags clear by writing one
        if (acc_wr && i_paddr == `REG_ADDR)  nxt_addr  = i_pwdata[19:0];
        if (acc_wr && i_paddr == `REG_WDATA) nxt_wdata = i_pwdata[15:0];
        if (acc_wr && i_paddr == `REG_STATUS) begin
            if (i_pwdata[`STAT_REDO])    nxt_redo    = 1'b0;
            if (i_pwdata[`STAT_REFUSED]) nxt_refused = 1'b0;
        end
        if (acc_wr && i_paddr == `REG_CTRL) begin
            nxt_byte   = i_pwdata[`CTRL_BYTE];
            nxt_top    = i_pwdata[`CTRL_TOP];
            nxt_hv_cfg = i_pwdata[`CTRL_HV];
            if (i_pwdata[`CTRL_START]) begin
                // command writes refused while the elevated voltage is applied
                if (state_ff != flash_host_pkg::S_IDLE || pins_ff.hv_en || i_pwdata[`CTRL_HV] ||
                    i_pwdata[`CTRL_OP_HI:`CTRL_OP_LO] > 3'd4) begin
                    nxt_refused = 1'b1;
                end else begin
                    nxt_op  = flash_host_pkg::op_t'(i_pwdata[`CTRL_OP_HI:`CTRL_OP_LO]);
                    nxt_seq = 2'd0;
                    unique case (nxt_op)
                        flash_host_pkg::OP_READ: begin
                            nxt_state = flash_host_pkg::S_RD;
                            nxt_cnt   = 16'(`ACCESS_CYC);
                        end
                        flash_host_pkg::OP_CLEAR: begin
                            nxt_state = flash_host_pkg::S_RST_LOW;
                            nxt_cnt   = 16'(`CLEAR_PULSE_CYC);
                        end
                        default: begin
                            nxt_state = flash_host_pkg::S_WR;
                            nxt_cnt   = 16'(`WE_LOW_CYC);
                        end
                    endcase
                end
            end
        end
        // sequencer
        unique case (state_ff)
            flash_host_pkg::S_IDLE: begin
            end
            flash_host_pkg::S_RD: begin
                // data taken only after the full access time
                if (cnt_ff == 16'h0000) begin
                    // same read path serves status polling; byte width keeps low byte
                    nxt_rdata = byte_ff ? {8'h00, i_dq[7:0]} : i_dq;
                    nxt_state = flash_host_pkg::S_IDLE;
                end else begin
                    nxt_cnt = cnt_ff - 16'h0001;
                end
            end
            flash_host_pkg::S_WR: begin
                if (cnt_ff == 16'h0000) begin
                    nxt_state = flash_host_pkg::S_WR_GAP;
                    nxt_cnt   = 16'(`WE_HIGH_CYC);
                end else begin
                    nxt_cnt = cnt_ff - 16'h0001;
                end
            end
            flash_host_pkg::S_WR_GAP: begin
                if (cnt_ff != 16'h0000) begin
                    nxt_cnt = cnt_ff - 16'h0001;
                end else if (seq_last) begin
                    nxt_state = flash_host_pkg::S_IDLE;
                    if (op_ff == flash_host_pkg::OP_ID_ENTER) nxt_id_mode = 1'b1;
                    if (op_ff == flash_host_pkg::OP_ID_EXIT)  nxt_id_mode = 1'b0;
                end else begin
                    nxt_seq   = 2'(seq_ff + 2'd1);
                    nxt_state = flash_host_pkg::S_WR;
                    nxt_cnt   = 16'(`WE_LOW_CYC);
                end
            end
            flash_host_pkg::S_RST_LOW: begin
                // embedded work cut by the reset is flagged for restart
                if (!i_op_done_flag) nxt_redo = 1'b1;
                if (cnt_ff == 16'h0000) begin
                    nxt_state   = flash_host_pkg::S_RST_REC;
                    nxt_cnt     = 16'(`CLEAR_RELEASE_CYC);
                    nxt_id_mode = 1'b0;
                end else begin
                    nxt_cnt = cnt_ff - 16'h0001;
                end
            end
            flash_host_pkg::S_RST_REC: begin
                // no read until the release-to-read time has passed
                if (cnt_ff == 16'h0000) nxt_state = flash_host_pkg::S_IDLE;
                else                    nxt_cnt   = cnt_ff - 16'h0001;
            end
        endcase
    end

    // pins follow the next state so each comes straight from a flip-flop
    always_comb begin
        nxt_pins.ce_n    = !(nxt_state == flash_host_pkg::S_RD || nxt_state == flash_host_pkg::S_WR);
        nxt_pins.oe_n    = nxt_state != flash_host_pkg::S_RD;
        nxt_pins.we_n    = nxt_state != flash_host_pkg::S_WR;
        nxt_pins.reset_n = nxt_state != flash_host_pkg::S_RST_LOW;
        nxt_pins.byte_n  = !nxt_byte;
        // elevated voltage only outside write steps
        nxt_pins.hv_en   = nxt_hv_cfg && nxt_state != flash_host_pkg::S_WR &&
                           nxt_state != flash_host_pkg::S_WR_GAP;
        // sector address placed on the high address bits from the address register
        nxt_pins.addr    = nxt_byte ? cmd_addr[19:1] : cmd_addr[18:0];
        nxt_dq           = {nxt_byte ? cmd_addr[0] : cmd_data[15], cmd_data[14:0]};
        nxt_dq_oe        = 16'h0000;
        if (nxt_state == flash_host_pkg::S_WR || nxt_state == flash_host_pkg::S_WR_GAP) begin
            nxt_dq_oe = nxt_byte ? 16'h00FF : 16'hFFFF;
        end
        if (nxt_byte) nxt_dq_oe[15] = 1'b1;
    end

    // registers
    always_ff @(posedge i_mclk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            state_ff   <= flash_host_pkg::S_IDLE;
            op_ff      <= flash_host_pkg::OP_READ;
            pins_ff    <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b1, byte_n: 1'b1,
                            hv_en: 1'b0, addr: 19'h00000};
            cnt_ff     <= 16'h0000;
            seq_ff     <= 2'd0;
            addr_ff    <= 20'h00000;
            wdata_ff   <= 16'h0000;
            rdata_ff   <= 16'h0000;
            dq_ff      <= 16'h0000;
            dq_oe_ff   <= 16'h0000;
            byte_ff    <= 1'b0;
            top_ff     <= 1'b0;
            hv_cfg_ff  <= 1'b0;
            id_mode_ff <= 1'b0;
            redo_ff    <= 1'b0;
            refused_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            op_ff      <= nxt_op;
            pins_ff    <= nxt_pins;
            cnt_ff     <= nxt_cnt;
            seq_ff     <= nxt_seq;
            addr_ff    <= nxt_addr;
            wdata_ff   <= nxt_wdata;
            rdata_ff   <= nxt_rdata;
            dq_ff      <= nxt_dq;
            dq_oe_ff   <= nxt_dq_oe;
            byte_ff    <= nxt_byte;
            top_ff     <= nxt_top;
            hv_cfg_ff  <= nxt_hv_cfg;
            id_mode_ff <= nxt_id_mode;
            redo_ff    <= nxt_redo;
            refused_ff <= nxt_refused;
            prdata_ff  <= nxt_prdata;
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    assign o_pins    = pins_ff;
    assign o_dq      = dq_ff;
    assign o_dq_oe   = dq_oe_ff;
    assign o_prdata  = prdata_ff;
    assign o_pready  = pready_ff;
    assign o_pslverr = pslverr_ff;

    // ==================================================
    // checks
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!rst_n_ff);
    sequence seq_rst_end;
        state_ff == flash_host_pkg::S_RST_LOW && cnt_ff == 16'h0000;
    endsequence
    sequence seq_cmd_end;
        state_ff == flash_host_pkg::S_WR_GAP && cnt_ff == 16'h0000 && seq_last;
    endsequence
    a_rd_access_wait: assert property ((state_ff == flash_host_pkg::S_RD && cnt_ff != 16'h0000)
        |=> state_ff == flash_host_pkg::S_RD) else $error("read ended before access time");
    a_rd_status_strobe: assert property (state_ff == flash_host_pkg::S_RD
        |-> !o_pins.ce_n && !o_pins.oe_n && o_pins.we_n && o_dq_oe[7:0] == 8'h00)
        else $error("read strobes wrong");
    a_rst_release_wait: assert property (seq_rst_end |=> o_pins.reset_n && o_pins.ce_n
        && state_ff == flash_host_pkg::S_RST_REC) else $error("read not held off after reset");
    a_rst_rec_ohold: assert property ($rose(o_pins.reset_n) |-> state_ff == flash_host_pkg::S_RST_REC)
        else $error("reset released outside recovery");
    a_redo_flag_set: assert property ((state_ff == flash_host_pkg::S_RST_LOW && !i_op_done_flag)
        |=> redo_ff [*2]) else $error("interrupted work not flagged");
    a_id_enter_done: assert property ((seq_cmd_end and op_ff == flash_host_pkg::OP_ID_ENTER)
        |=> id_mode_ff && state_ff == flash_host_pkg::S_IDLE) else $error("id mode not entered");
    a_id_exit_done: assert property ((seq_cmd_end and op_ff == flash_host_pkg::OP_ID_EXIT)
        |=> !id_mode_ff && $past(o_dq[7:0]) == 8'hF0) else $error("id mode not left");
    a_wr_no_hv: assert property ((state_ff == flash_host_pkg::S_WR) |-> !o_pins.hv_en && !o_pins.we_n
        && o_pins.oe_n && !o_pins.ce_n) else $error("command write with elevated voltage");
    a_hv_no_write: assert property (o_pins.hv_en |-> o_pins.we_n)
        else $error("elevated voltage during write strobe");
endmodule

// file: inc/flash_host_pkg.sv
// types of the flash host controller
package flash_host_pkg;
    // ==================================================
    // controller states and operations
    typedef enum logic [2:0] {S_IDLE, S_RD, S_WR, S_WR_GAP, S_RST_LOW, S_RST_REC} state_t;
    typedef enum logic [2:0] {OP_READ, OP_WRITE, OP_ID_ENTER, OP_ID_EXIT, OP_CLEAR} op_t;
    // ==================================================
    // flash control pins, all driven together
    typedef struct packed {
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic        reset_n;
        logic        byte_n;
        logic        hv_en;
        logic [18:0] addr;
    } flash_pins_t;
endpackage

// file: inc/flash_host_regs.svh
// register map, field positions, command words and timing counts of the flash host controller
`ifndef FLASH_HOST_REGS_SVH
`define FLASH_HOST_REGS_SVH
// ==================================================
// register offsets (byte addresses, one word each)
`define REG_CTRL         8'h00
`define REG_ADDR         8'h04
`define REG_WDATA        8'h08
`define REG_RDATA        8'h0C
`define REG_STATUS       8'h10
// ==================================================
// control fields
`define CTRL_START       0
`define CTRL_OP_LO       1
`define CTRL_OP_HI       3
`define CTRL_BYTE        4
`define CTRL_TOP         5
`define CTRL_HV          6
// status fields
`define STAT_BUSY        0
`define STAT_ID          1
`define STAT_DONE        2
`define STAT_REDO        3
`define STAT_REFUSED     4
`define STAT_SEC_LO      8
`define STAT_SEC_HI      12
// ==================================================
// command words (word-mode and byte-mode unlock addresses)
`define UNLOCK1_WADDR    20'h00555
`define UNLOCK2_WADDR    20'h002AA
`define UNLOCK1_BADDR    20'h00AAA
`define UNLOCK2_BADDR    20'h00555
`define UNLOCK1_DATA     16'h00AA
`define UNLOCK2_DATA     16'h0055
`define ID_CMD_DATA      16'h0090
`define RESET_CMD_DATA   16'h00F0
// ==================================================
// timing, in ns, and cycle counts at the clock rate (least times round up)
`define CLK_MHZ              40
`define ACCESS_TIME_NS       100
`define WE_LOW_TIME_NS       50
`define WE_HIGH_TIME_NS      30
`define MIN_CLEAR_PULSE_NS   500
`define CLEAR_RELEASE_NS     50
`define NS_TO_CYC(ns)        (((ns) * `CLK_MHZ + 999) / 1000)
`define ACCESS_CYC           `NS_TO_CYC(`ACCESS_TIME_NS)
`define WE_LOW_CYC           `NS_TO_CYC(`WE_LOW_TIME_NS)
`define WE_HIGH_CYC          `NS_TO_CYC(`WE_HIGH_TIME_NS)
`define CLEAR_PULSE_CYC      `NS_TO_CYC(`MIN_CLEAR_PULSE_NS)
`define CLEAR_RELEASE_CYC    `NS_TO_CYC(`CLEAR_RELEASE_NS)
`endif

// file: tb/flash_dev_model.sv
// behavioural parallel nor flash answering the host controller's pins
module flash_dev_model #(
    parameter logic [7:0] MAKER_CODE = 8'h3A,  // arbitrary value
    parameter logic [7:0] PART_CODE  = 8'h6B   // arbitrary value
) (
    input  flash_host_pkg::flash_pins_t i_pins,
    input  wire logic [15:0]            i_dq,
    input  wire logic                   i_embed,
    output logic      [15:0]            o_dq,
    output logic                        o_done_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        id_mode = 1'b0;
    logic        busy    = 1'b0;
    logic [1:0]  seq     = 2'h0;
    logic [15:0] val;
    logic [15:0] last    = 16'h0000;
    wire         drv     = i_pins.reset_n && !i_pins.ce_n && !i_pins.oe_n && i_pins.we_n;
    wire         wr_act  = i_pins.reset_n && !i_pins.ce_n && !i_pins.we_n && i_pins.oe_n;
    logic [15:0] wr_data = 16'h0000;
    logic [18:0] wr_addr = 19'h00000;
    // array or id data in word width; byte width gives array low byte only
    always @* begin
        val = id_mode ? {8'h00, i_pins.addr[0] ? PART_CODE : MAKER_CODE} : i_pins.addr[15:0] ^ 16'h3C3C;
        if (!i_pins.byte_n) begin
            val = {~last[15:8], i_pins.addr[7:0] ^ 8'h3C};
        end
    end
    assign o_dq = drv ? val : ~last;
    always @(negedge drv) last = val;
    // address taken as the write strobe opens
    always @(posedge wr_act) wr_addr = i_pins.addr;
    // unlock sequence and reset command, data taken as the strobe closes
    always @(negedge wr_act) begin
        if (i_pins.reset_n) begin
            wr_data = i_dq;
            case (i_dq[7:0])
                8'hAA: seq = 2'h1;
                8'h55: seq = (seq == 2'h1) ? 2'h2 : 2'h0;
                8'h90: id_mode = id_mode | (seq == 2'h2);
                8'hF0: id_mode = 1'b0;
                default: seq = 2'h0;
            endcase
        end
    end
    always @(negedge i_pins.reset_n) begin
        id_mode = 1'b0;
        seq = 2'h0;
    end
    // busy ends only after the clear completes
    always @(posedge i_embed) busy = 1'b1;
    always @(posedge i_pins.reset_n) if (busy) #100 busy = 1'b0;
    assign o_done_flag = !busy;
endmodule

// file: tb/flash_host_ctrl_test.sv
// self-checking bench of the flash host controller
`include "flash_host_regs.svh"
module flash_host_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic                        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, embed = 0, pready, pslverr, ev;
    logic [7:0]                  paddr = 8'h00;
    logic [31:0]                 pwdata = 32'h0, prdata, rv;
    logic [15:0]                 dq_out, dq_oe, m_dq, dq_bus;
    logic                        done_flag;
    flash_host_pkg::flash_pins_t pins;
    int                          n_errors = 0, n_tests = 0, cyc = 0, rst_low = 0, rst_last = 0, rd_low = 0, rd_last = 0;
    logic [19:0]                 sa_a [9] = '{20'h00000, 20'h02000, 20'h03000, 20'h04000, 20'h08000, 20'h78000,
                                              20'h7C000, 20'h7D000, 20'h7E000};
    logic [4:0]                  sa_x [2][9] = '{'{0, 0, 0, 0, 1, 15, 16, 17, 18}, '{0, 1, 2, 3, 4, 18, 18, 18, 18}};
    assign dq_bus = (dq_oe & dq_out) | (~dq_oe & m_dq);
    flash_host_ctrl dut (.i_mclk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .o_pins(pins), .i_dq(dq_bus), .o_dq(dq_out), .o_dq_oe(dq_oe), .i_op_done_flag(done_flag));
    flash_dev_model dev (.i_pins(pins), .i_dq(dq_bus), .i_embed(embed), .o_dq(m_dq), .o_done_flag(done_flag));
    initial begin
        forever #12.5 clk = ~clk;
    end
    // pulse-width monitors and run-time ceiling
    always @(posedge clk) begin
        cyc <= cyc + 1;
        rst_low <= (pins.reset_n === 1'b0) ? rst_low + 1 : 0;
        if (pins.reset_n === 1'b1 && rst_low != 0) rst_last <= rst_low;
        rd_low <= (pins.ce_n === 1'b0 && pins.oe_n === 1'b0) ? rd_low + 1 : 0;
        if (pins.oe_n === 1'b1 && rd_low != 0) rd_last <= rd_low;
        if (cyc == 20000) begin
            n_errors++;
            final_report();
        end
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic op(input logic [19:0] a, input logic [31:0] ctrl);
        apb(1, `REG_ADDR, {12'h0, a});
        apb(1, `REG_CTRL, ctrl | 32'h1);
        do begin
            apb(0, `REG_STATUS, 0);
        end while (rv[`STAT_BUSY] !== 1'b0);
    endtask
    task automatic t_basic;
        chk("pins idle", {pins.ce_n, pins.oe_n, pins.we_n, pins.reset_n}, 4'hF);
        apb(0, 8'h20, 0);
        chk("unmapped error", ev, 1'b1);
        chk("unmapped data", rv, 32'h0);
        chk("unmapped idle", {pins.ce_n, pins.oe_n, pins.we_n, pins.reset_n}, 4'hF);
        op(20'h01234, 0);
        apb(0, `REG_RDATA, 0);
        chk("word read", rv, 32'h2E08);
        chk("read time", rd_last, `ACCESS_CYC + 1);
        chk("read float", dq_oe, 16'h0000);
        apb(1, `REG_WDATA, 32'h5A5A);
        op(20'h12345, 32'h2);
        chk("write addr", dev.wr_addr, 32'h12345);
        chk("write data", dev.wr_data, 32'h5A5A);
        op(20'h00AB5, 32'h10);
        apb(0, `REG_RDATA, 0);
        chk("byte read", rv, 32'h66);
        $display("basic read test done");
    endtask
    task automatic t_id;
        op(0, 32'h4);
        chk("id on", rv[`STAT_ID], 1'b1);
        chk("unlock addr", dev.wr_addr, 32'h555);
        chk("id cmd", dev.wr_data[7:0], 8'h90);
        op(0, 0);
        apb(0, `REG_RDATA, 0);
        chk("maker", rv, 32'h3A);
        op(1, 0);
        apb(0, `REG_RDATA, 0);
        chk("part", rv, 32'h6B);
        op(0, 32'h6);
        chk("id off", rv[`STAT_ID], 1'b0);
        chk("reset cmd", dev.wr_data[7:0], 8'hF0);
        op(0, 0);
        apb(0, `REG_RDATA, 0);
        chk("array back", rv, 32'h3C3C);
        $display("identification test done");
    endtask
    task automatic t_clear;
        op(0, 32'h4);
        embed <= 1'b1;
        op(0, 32'h8);
        chk("pulse", rst_last, `CLEAR_PULSE_CYC + 1);
        chk("redo id", rv & 32'hA, 32'h8);
        op(0, 0);
        apb(0, `REG_RDATA, 0);
        chk("after clear", rv, 32'h3C3C);
        apb(1, `REG_STATUS, 32'h8);
        apb(0, `REG_STATUS, 0);
        chk("redo w1c", rv[`STAT_REDO], 1'b0);
        embed <= 1'b0;
        $display("clear test done");
    endtask
    task automatic t_refuse;
        apb(1, `REG_CTRL, 32'h41);
        apb(0, `REG_STATUS, 0);
        chk("refused", {pins.hv_en, rv[4:0]}, 6'h34);
        apb(1, `REG_CTRL, 0);
        apb(1, `REG_STATUS, 32'h10);
        $display("refusal test done");
    endtask
    task automatic t_sector;
        for (int t = 0; t < 2; t++) begin
            apb(1, `REG_CTRL, t ? 32'h0 : 32'h20);
            for (int i = 0; i < 9; i++) begin
                apb(1, `REG_ADDR, {12'h0, sa_a[i]});
                apb(0, `REG_STATUS, 0);
                chk("sector", rv[12:8], sa_x[t][i]);
            end
        end
        apb(1, `REG_CTRL, 32'h30);
        apb(1, `REG_ADDR, 32'hF8000);
        apb(0, `REG_STATUS, 0);
        chk("byte sector", rv[12:8], 5'd16);
        $display("sector test done");
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_basic();
        t_id();
        t_clear();
        t_refuse();
        t_sector();
        final_report();
    end
endmodule
